// ==== hw/event_sel_pkg.sv ====
package event_sel_pkg;

  // ********************************************************
  // sizes
  // ********************************************************
  localparam int CHANNELS     = 16;
  localparam int PROG_SLOTS   = 12;
  localparam int FIELDS_PER   = 4;
  localparam int CODE_W       = 6;
  localparam int CODE_COUNT   = 16;
  localparam int PIN_COUNT    = 4;
  localparam int CHAIN_COUNT  = 4;
  localparam int CHAIN_BASE   = 8;
  localparam int HIGH_BASE    = 12;
  localparam int FIELD_STRIDE = 8;

  // ********************************************************
  // register map (byte addresses)
  // ********************************************************
  localparam logic [31:0] SEL_CH0_3_ADDR   = 32'h01A0FF00;
  localparam logic [31:0] SEL_CH4_7_ADDR   = 32'h01A0FF04;
  localparam logic [31:0] SEL_CH12_15_ADDR = 32'h01A0FF0C;
  localparam logic [31:0] PIN_CTRL_ADDR    = 32'h01A0FF10;

  // pin control register layout
  localparam int POL_LSB   = 0;
  localparam int LEVEL_LSB = 4;

  localparam logic [3:0] POL_RESET = 4'h0;

  // ********************************************************
  // event codes
  // ********************************************************
  localparam logic [5:0] CODE_NONE    = 6'h00;
  localparam logic [5:0] CODE_TIMER0  = 6'h01;
  localparam logic [5:0] CODE_TIMER1  = 6'h02;
  localparam logic [5:0] CODE_SDRAM   = 6'h03;
  localparam logic [5:0] CODE_PIN4    = 6'h04;
  localparam logic [5:0] CODE_PIN2    = 6'h0A;
  localparam logic [5:0] CODE_SER0_TX = 6'h0C;
  localparam logic [5:0] CODE_LIMIT   = 6'h10;

  // one bit per code below CODE_LIMIT, set where an event exists
  localparam logic [15:0] CODE_VALID_MASK = 16'hF4FE;

endpackage

// ==== hw/code_decoder.sv ====
`timescale 1ns/1ps

// ********************************************************
// one channel's code lookup
// ********************************************************
module code_decoder (
  input  wire logic [5:0]  code,
  input  wire logic [15:0] events_by_code,
  output logic             hit,
  output logic             valid
);

  wire       in_range;
  wire [3:0] index;

  assign in_range = code < event_sel_pkg::CODE_LIMIT;
  assign index    = code[3:0];
  // reserved codes never fire, even if the event line is high
  assign valid    = in_range
                  & event_sel_pkg::CODE_VALID_MASK[index];
  assign hit      = valid & events_by_code[index];

endmodule // code_decoder

// ==== hw/event_selector.sv ====
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps

// Notes on behaviour
// - sixteen channel triggers, twelve routable and four for chaining.
// - channels 8 to 11 follow only chain completion codes 8 to 11.
// - the fixed variant wires code n to channel n; channel 0 gets no event.
// - the three selector registers sit at FF00, FF04 and FF0C.
// - each selector holds four 6-bit fields at bytes 0 to 3.
// - fields for channels 0 to 7 reset to their channel number.
// - fields for channels 12 to 15 reset to codes 8 to 11.
// - codes 1 to 7 select timers, sdram refresh and pins 4 to 7.
// - code 10 is pin 2, 12 to 15 the serial events, others reserved.
// - any event may drive any routable channel, several at once.
// - pin events 4 to 7 come from the external pins 4 to 7.
// - pin events are edge detected, edge chosen per pin by polarity.
module event_selector #(
  parameter bit FIXED_MAP = 1'b0
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [31:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        timer0_event,
  input  wire logic        timer1_event,
  input  wire logic        sdram_refresh_event,
  input  wire logic        pin2_event,
  input  wire logic [3:0]  ext_pins,
  input  wire logic        serial0_tx_event,
  input  wire logic        serial0_rx_event,
  input  wire logic        serial1_tx_event,
  input  wire logic        serial1_rx_event,
  input  wire logic [3:0]  chain_complete,
  output logic      [15:0] channel_trigger
);

  // ********************************************************
  // reset release
  // ********************************************************
  logic rst_meta_reg;
  logic rst_q_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_q_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_q_reg    <= rst_meta_reg;
    end
  end

  // ********************************************************
  // avalon slave: one wait cycle on every access
  // ********************************************************
  logic        ack_reg;
  logic [31:0] readdata_reg;
  logic [3:0]  pol_reg;
  logic [5:0]  field_reg [event_sel_pkg::PROG_SLOTS];

  wire        request;
  wire        hit_sel0;
  wire        hit_sel1;
  wire        hit_sel3;
  wire        hit_pin;
  wire        write_now;
  wire [31:0] sel0_word;
  wire [31:0] sel1_word;
  wire [31:0] sel3_word;
  wire [31:0] pin_word;
  wire [31:0] read_word;
  wire [3:0]  pin_level;

  assign request   = read | write;
  assign waitrequest = request & ~ack_reg;
  assign write_now = write & ack_reg;
  assign hit_sel0  = address == event_sel_pkg::SEL_CH0_3_ADDR;
  assign hit_sel1  = address == event_sel_pkg::SEL_CH4_7_ADDR;
  assign hit_sel3  = address == event_sel_pkg::SEL_CH12_15_ADDR;
  assign hit_pin   = address == event_sel_pkg::PIN_CTRL_ADDR;

  // reserved bits 7:6 of each byte read as zero
  assign sel0_word = {2'h0, field_reg[3],  2'h0, field_reg[2],
                      2'h0, field_reg[1],  2'h0, field_reg[0]};
  assign sel1_word = {2'h0, field_reg[7],  2'h0, field_reg[6],
                      2'h0, field_reg[5],  2'h0, field_reg[4]};
  assign sel3_word = {2'h0, field_reg[11], 2'h0, field_reg[10],
                      2'h0, field_reg[9],  2'h0, field_reg[8]};
  assign pin_word  = {24'h000000, pin_level, pol_reg};
  // unmapped addresses read as zero
  assign read_word = hit_sel0 ? sel0_word :
                     hit_sel1 ? sel1_word :
                     hit_sel3 ? sel3_word :
                     hit_pin  ? pin_word  : 32'h00000000;

  always_ff @(posedge clock or negedge rst_q_reg) begin
    if (!rst_q_reg) begin
      ack_reg      <= 1'b0;
      readdata_reg <= 32'h00000000;
    end else begin
      ack_reg      <= request & ~ack_reg;
      readdata_reg <= read_word;
    end
  end

  assign readdata = readdata_reg;

  always_ff @(posedge clock or negedge rst_q_reg) begin
    if (!rst_q_reg) begin
      pol_reg <= event_sel_pkg::POL_RESET;
    end else if (write_now && hit_pin && byteenable[0]) begin
      pol_reg <= writedata[event_sel_pkg::POL_LSB +: 4];
    end
  end

  // ********************************************************
  // code fields, one byte lane per field
  // ********************************************************
  genvar s;
  generate
    for (s = 0; s < event_sel_pkg::PROG_SLOTS; s++) begin : g_field
      localparam int LANE = s % event_sel_pkg::FIELDS_PER;
      localparam int LSB  = LANE * event_sel_pkg::FIELD_STRIDE;
      localparam logic [5:0] RESET_CODE = 6'(s);
      wire in_reg;
      wire take;

      if (s < event_sel_pkg::FIELDS_PER) begin : g_r0
        assign in_reg = hit_sel0;
      end else if (s < event_sel_pkg::CHAIN_BASE) begin : g_r1
        assign in_reg = hit_sel1;
      end else begin : g_r3
        assign in_reg = hit_sel3;
      end
      assign take = write_now & in_reg & byteenable[LANE];

      always_ff @(posedge clock or negedge rst_q_reg) begin
        if (!rst_q_reg) begin
          field_reg[s] <= RESET_CODE;
        end else if (take) begin
          field_reg[s] <= writedata[LSB +: event_sel_pkg::CODE_W];
        end
      end
    end
  endgenerate

  // ********************************************************
  // external pins: two-stage sync, then edge detect
  // ********************************************************
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic [3:0] pin_prev_reg;
  logic [3:0] pin_evt_reg;

  wire  [3:0] pin_rise;
  wire  [3:0] pin_fall;
  wire  [3:0] pin_edge;

  always_ff @(posedge clock or negedge rst_q_reg) begin
    if (!rst_q_reg) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
      pin_prev_reg <= 4'h0;
      pin_evt_reg  <= 4'h0;
    end else begin
      pin_meta_reg <= ext_pins;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
      pin_evt_reg  <= pin_edge;
    end
  end

  assign pin_level = pin_sync_reg;
  assign pin_rise  = pin_sync_reg & ~pin_prev_reg;
  assign pin_fall  = ~pin_sync_reg & pin_prev_reg;
  // polarity 0 picks the rising edge, 1 the falling edge
  assign pin_edge  = (pin_rise & ~pol_reg) | (pin_fall & pol_reg);

  // ********************************************************
  // event vector indexed by code
  // ********************************************************
  wire [15:0] events_by_code;

  assign events_by_code = {serial1_rx_event, serial1_tx_event,
                           serial0_rx_event, serial0_tx_event,
                           1'b0, pin2_event, 2'h0,
                           pin_evt_reg,
                           sdram_refresh_event, timer1_event,
                           timer0_event, 1'b0};

  // ********************************************************
  // channel selection and pulse shaping
  // ********************************************************
  logic [15:0] sel_prev_reg;
  logic [15:0] trig_reg;
  wire  [15:0] sel_level;
  wire  [11:0] slot_valid;

  generate
    for (s = 0; s < event_sel_pkg::PROG_SLOTS; s++) begin : g_slot
      // slots 0-7 feed channels 0-7, slots 8-11 feed 12-15
      localparam int CH = (s < event_sel_pkg::CHAIN_BASE) ?
                          s : s + event_sel_pkg::CHAIN_COUNT;
      localparam logic [5:0] FIXED_CODE = 6'(CH);
      wire [5:0] code;

      assign code = FIXED_MAP ? FIXED_CODE : field_reg[s];
      code_decoder u_dec (
        .code           (code),
        .events_by_code (events_by_code),
        .hit            (sel_level[CH]),
        .valid          (slot_valid[s])
      );
    end
  endgenerate

  // chaining channels have no field at all
  assign sel_level[11:8] = chain_complete;

  always_ff @(posedge clock or negedge rst_q_reg) begin
    if (!rst_q_reg) begin
      sel_prev_reg <= 16'h0000;
      trig_reg     <= 16'h0000;
    end else begin
      sel_prev_reg <= sel_level;
      // a level held high by the source still gives one pulse
      trig_reg     <= sel_level & ~sel_prev_reg;
    end
  end

  assign channel_trigger = trig_reg;

  // ********************************************************
  // checks
  // ********************************************************
  a_chain_low_pass: assert property (
    @(posedge clock) disable iff (!rst_q_reg)
    $rose(chain_complete[0]) |=> channel_trigger[8])
    else $error("chain completion 8 did not trigger channel 8");

  a_chain_high_pass: assert property (
    @(posedge clock) disable iff (!rst_q_reg)
    $rose(chain_complete[3]) |=> channel_trigger[11])
    else $error("chain completion 11 did not trigger channel 11");

  a_reserved_quiet: assert property (
    @(posedge clock) disable iff (!rst_q_reg)
    !slot_valid[0] |=> !channel_trigger[0])
    else $error("channel with reserved code fired");

  a_trigger_pulse: assert property (
    @(posedge clock) disable iff (!rst_q_reg)
    channel_trigger[1] |=> !channel_trigger[1])
    else $error("trigger held longer than one cycle");

  a_reset_fields: assert property (
    @(posedge clock)
    $rose(rst_q_reg) |-> field_reg[0] == 6'h00 &&
                         field_reg[7] == 6'h07)
    else $error("low channel fields not at reset codes");

  a_reset_high: assert property (
    @(posedge clock)
    $rose(rst_q_reg) |-> field_reg[8] == 6'h08 &&
                         field_reg[11] == 6'h0B)
    else $error("high channel fields not at reset codes");

  a_timer_route: assert property (
    @(posedge clock) disable iff (!rst_q_reg || FIXED_MAP)
    field_reg[1] == event_sel_pkg::CODE_TIMER0 &&
    $stable(field_reg[1]) && $rose(timer0_event)
    |=> channel_trigger[1])
    else $error("timer 0 event not routed to channel 1");

  a_pin_edge: assert property (
    @(posedge clock) disable iff (!rst_q_reg)
    !pol_reg[0] && $rose(pin_sync_reg[0]) |=> pin_evt_reg[0])
    else $error("rising pin edge missed");

  a_read_sel0: assert property (
    @(posedge clock) disable iff (!rst_q_reg)
    read && !waitrequest && $stable(address) &&
    address == event_sel_pkg::SEL_CH0_3_ADDR
    |-> readdata == $past(sel0_word))
    else $error("selector read data wrong");

  a_write_field: assert property (
    @(posedge clock) disable iff (!rst_q_reg)
    write && !waitrequest && byteenable[1] &&
    address == event_sel_pkg::SEL_CH0_3_ADDR
    |=> field_reg[1] == $past(writedata[13:8]))
    else $error("field 1 write lost");

  a_wait_bounded: assert property (
    @(posedge clock) disable iff (!rst_q_reg)
    $rose(read) |-> waitrequest ##1 !waitrequest)
    else $error("read not answered after one wait cycle");

  a_unmapped_zero: assert property (
    @(posedge clock) disable iff (!rst_q_reg)
    read && !waitrequest && $stable(address) &&
    address == 32'h01A0FF08 |-> readdata == 32'h00000000)
    else $error("unmapped read not zero");

endmodule // event_selector

// ==== test/event_source_model.sv ====
`timescale 1ns/1ps

// ********************************************************
// far side: event sources and pins feeding the selector
// ********************************************************
module event_source_model (
  input  wire logic        clock,
  output logic      [11:0] events,
  output logic      [3:0]  pins
);
  initial begin
    events = 12'h000;
    pins   = 4'h0;
  end

  // one-cycle pulse, then a low cycle before any next pulse
  task automatic pulse(input int idx);
    @(posedge clock);
    events <= 12'h001 << idx;
    @(posedge clock);
    events <= 12'h000;
  endtask

  // pins are only ever driven as device inputs
  task automatic set_pins(input logic [3:0] val);
    @(posedge clock);
    pins <= val;
  endtask
endmodule // event_source_model

// ==== test/tb.sv ====
`timescale 1ns/1ps

// ********************************************************
// selector bench
// ********************************************************
module tb;
  logic        clock;
  logic        rst_b;
  logic [31:0] address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [11:0] events;
  logic [3:0]  pins;
  logic [15:0] channel_trigger;
  logic [15:0] fixed_trigger;
  int          errors;
  int          tests_run;

  event_selector #(.FIXED_MAP(1'b0)) u_event_selector (
    .clock(clock), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .timer0_event(events[0]), .timer1_event(events[1]),
    .sdram_refresh_event(events[2]), .pin2_event(events[3]),
    .ext_pins(pins),
    .serial0_tx_event(events[4]), .serial0_rx_event(events[5]),
    .serial1_tx_event(events[6]), .serial1_rx_event(events[7]),
    .chain_complete(events[11:8]), .channel_trigger(channel_trigger)
  );

  // hardwired variant on the same bus: its selector writes are ignored
  event_selector #(.FIXED_MAP(1'b1)) u_event_selector_fixed (
    .clock(clock), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(), .waitrequest(),
    .timer0_event(events[0]), .timer1_event(events[1]),
    .sdram_refresh_event(events[2]), .pin2_event(events[3]),
    .ext_pins(pins),
    .serial0_tx_event(events[4]), .serial0_rx_event(events[5]),
    .serial1_tx_event(events[6]), .serial1_rx_event(events[7]),
    .chain_complete(events[11:8]), .channel_trigger(fixed_trigger)
  );

  event_source_model u_event_source_model (
    .clock(clock), .events(events), .pins(pins)
  );

  always #12.5 clock = ~clock;

  // ********************************************************
  // compare and bus tasks
  // ********************************************************
  task automatic check32(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic check16(input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge;
  // only the watchdog ends a wait that never gets an answer
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    @(posedge clock);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    byteenable <= be;
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic reg_expect(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, 4'hF, q);
    check32(e, q);
  endtask

  task automatic fire(input int idx, input logic [15:0] e);
    u_event_source_model.pulse(idx);
    #1;
    check16(e, channel_trigger);
    @(posedge clock);
    #1;
    check16(16'h0000, channel_trigger);
  endtask

  task automatic fire_fixed(input int idx, input logic [15:0] e);
    u_event_source_model.pulse(idx);
    #1;
    check16(e, fixed_trigger);
    @(posedge clock);
    #1;
    check16(16'h0000, fixed_trigger);
  endtask

  task automatic pin_watch(input logic [3:0] v, input int ch, input int e);
    int n;
    n = 0;
    u_event_source_model.set_pins(v);
    repeat (10) begin
      @(posedge clock);
      #1;
      if (channel_trigger[ch] === 1'b1) n++;
    end
    check32(32'(e), 32'(n));
  endtask

  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_reset;
    reg_expect(event_sel_pkg::SEL_CH0_3_ADDR, 32'h03020100);
    reg_expect(event_sel_pkg::SEL_CH4_7_ADDR, 32'h07060504);
    reg_expect(event_sel_pkg::SEL_CH12_15_ADDR, 32'h0B0A0908);
    reg_expect(32'h01A0FF08, 32'h00000000);
    $display("reset values done");
  endtask

  task automatic t_default;
    fire(0, 16'h0002);
    fire(1, 16'h0004);
    fire(2, 16'h0008);
    fire(3, 16'h4000);
    fire(4, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      fire(8 + i, 16'h0100 << i);
    end
    $display("default routing done");
  endtask

  task automatic t_pins;
    pin_watch(4'h1, 4, 1);
    pin_watch(4'h3, 5, 1);
    wr(event_sel_pkg::PIN_CTRL_ADDR, 32'h00000002, 4'hF);
    pin_watch(4'h1, 5, 1);
    pin_watch(4'h3, 5, 0);
    reg_expect(event_sel_pkg::PIN_CTRL_ADDR, 32'h00000032);
    $display("pin edges done");
  endtask

  task automatic t_reserved;
    wr(event_sel_pkg::SEL_CH0_3_ADDR, 32'hFFFFFFFF, 4'h2);
    reg_expect(event_sel_pkg::SEL_CH0_3_ADDR, 32'h03023F00);
    fire(0, 16'h0000);
    $display("reserved codes done");
  endtask

  task automatic t_route;
    // one event fanned out to several channels at once
    wr(event_sel_pkg::SEL_CH4_7_ADDR, 32'h02020202, 4'hF);
    fire(1, 16'h00F4);
    wr(event_sel_pkg::SEL_CH12_15_ADDR, 32'h0F0E0D0C, 4'hF);
    for (int i = 0; i < 4; i++) begin
      fire(4 + i, 16'h1000 << i);
    end
    $display("routing done");
  endtask

  task automatic t_fixed;
    fire_fixed(0, 16'h0002);
    fire_fixed(2, 16'h0008);
    fire_fixed(3, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      fire_fixed(4 + i, 16'h1000 << i);
      fire_fixed(8 + i, 16'h0100 << i);
    end
    $display("fixed map done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    address = 32'h00000000;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'hF;
    errors = 0;
    tests_run = 0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset();
    t_default();
    t_pins();
    t_reserved();
    t_route();
    t_fixed();
    tally_and_finish();
  end

  // about 160 cycles are expected; cut off far beyond that
  initial begin
    #500000;
    errors++;
    tally_and_finish();
  end
endmodule // tb
